// File: logic/pxled_top.sv
// Status indicator drivers and management address strap capture
//
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/1ns
module pxled_top #(
	parameter int STRETCH_CYCLES_P = pxled_pkg::STRETCH_CYCLES
) (
	// Clock and reset
	input  wire logic                           clock_in,
	input  wire logic                           rst_n_in,
	// Register bus (Avalon-MM slave)
	input  wire logic [pxled_pkg::ADDR_W-1:0]   address_in,
	input  wire logic                           read_in,
	input  wire logic                           write_in,
	input  wire logic [pxled_pkg::DATA_W-1:0]   writedata_in,
	input  wire logic [3:0]                     byteenable_in,
	output logic      [pxled_pkg::DATA_W-1:0]   readdata_out,
	output logic                                waitrequest_out,
	// Line status from the device core
	input  wire logic                           tx_active_in,
	input  wire logic                           carrier_sense_in,
	input  wire logic                           link_good_in,
	input  wire logic                           polarity_good_in,
	input  wire logic                           full_duplex_in,
	input  wire logic                           speed_100_in,
	input  wire logic                           collision_in,
	input  wire logic                           disconnect_in,
	input  wire logic                           loopback_enable_in,
	input  wire logic                           encode_select_in,
	input  wire logic                           rx_error_in,
	// Indicator pins, active low
	output logic                                tx_activity_indicator_n_out,
	output logic                                rx_activity_indicator_n_out,
	output logic                                link_good_indicator_n_out,
	output logic                                polarity_duplex_indicator_n_out,
	output logic                                collision_indicator_n_out,
	// Strap pins, sensed levels
	input  wire logic [pxled_pkg::STRAP_W-1:0]  strap_pin_in,
	// Dual-role strap pins, driven side
	output logic                                loopback_enable_out,
	output logic                                loopback_enable_oe_out,
	output logic                                encode_select_out,
	output logic                                encode_select_oe_out,
	output logic                                carrier_sense_out,
	output logic                                carrier_sense_oe_out,
	output logic                                rx_error_out,
	output logic                                rx_error_oe_out,
	// Address and isolation state
	output logic      [pxled_pkg::STRAP_W-1:0]  strap_address_out,
	output logic                                isolate_out
);
	import pxled_pkg::*;

	localparam int SETTLE_W = $clog2(STRAP_SETTLE_CYCLES);

	// ------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------
	generate
		if (STRETCH_CYCLES_P < 1) begin : g_bad_stretch
			$error("pxled_top: STRETCH_CYCLES_P must be at least 1");
		end
		if (ADDR_W != 8 || DATA_W != 32) begin : g_bad_bus
			$error("pxled_top: bus geometry must stay at 8 address and 32 data bits");
		end
	endgenerate

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------

	// Word index match on a byte address; the low two bits are lane offsets
	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [5:0] idx);
		return addr[ADDR_W-1:2] == idx;
	endfunction

	logic              ack_reg;
	logic              ack_next;
	logic [DATA_W-1:0] rd_word;
	logic [DATA_W-1:0] bcr_word;
	logic [DATA_W-1:0] cfg_word;
	logic [DATA_W-1:0] adr_word;
	logic              isolate_reg;
	logic              tx_alt_reg;
	logic              dup_alt_reg;
	logic              disconnect_flag_reg;
	logic [STRAP_W-1:0] strap_addr_reg;

	// Every access waits exactly one cycle, reads and writes alike
	wire bus_req  = read_in | write_in;
	wire wr_take  = write_in & ack_reg;
	wire rd_load  = read_in & ~ack_reg;
	wire hit_bcr  = reg_hit(address_in, IDX_BASIC_CTRL);
	wire hit_cfg  = reg_hit(address_in, IDX_PCS_CFG);
	wire hit_adr  = reg_hit(address_in, IDX_STRAP_ADDR);
	wire lane_bcr = byteenable_in[BCR_ISOLATE_BIT / 8];
	wire lane_cfg = byteenable_in[0];

	assign ack_next        = bus_req & ~ack_reg;
	assign waitrequest_out = bus_req & ~ack_reg;

	// Read words; bits not named here read as zero
	always_comb begin
		bcr_word                     = '0;
		bcr_word[BCR_ISOLATE_BIT]    = isolate_reg;
		cfg_word                     = '0;
		cfg_word[CFG_TX_ALT_BIT]     = tx_alt_reg;
		cfg_word[CFG_DUPLEX_ALT_BIT] = dup_alt_reg;
		adr_word                     = '0;
		adr_word[STRAP_W-1:0]        = strap_addr_reg;
		adr_word[ADR_DISCONNECT_BIT] = disconnect_flag_reg;
	end

	// Unmapped addresses read as zero and ignore writes
	assign rd_word = hit_bcr ? bcr_word :
		(hit_cfg ? cfg_word :
		(hit_adr ? adr_word : '0));

	// ------------------------------------------------------------
	// Register bus slave
	// ------------------------------------------------------------
	// Acknowledge and read data; data stands until the next read
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			ack_reg      <= 1'b0;
			readdata_out <= '0;
		end else begin
			ack_reg <= ack_next;
			if (rd_load) begin
				readdata_out <= rd_word;
			end
		end
	end

	// Software control bits, written only on the accepting edge
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			isolate_reg <= ISOLATE_RESET;
			tx_alt_reg  <= TX_ALT_RESET;
			dup_alt_reg <= DUPLEX_ALT_RESET;
		end else if (wr_take) begin
			if (hit_bcr && lane_bcr) begin
				isolate_reg <= writedata_in[BCR_ISOLATE_BIT];
			end
			if (hit_cfg && lane_cfg) begin
				tx_alt_reg  <= writedata_in[CFG_TX_ALT_BIT];
				dup_alt_reg <= writedata_in[CFG_DUPLEX_ALT_BIT];
			end
		end
	end

	// Disconnect state follows the core; it is status, not writable
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			disconnect_flag_reg <= 1'b0;
		end else begin
			disconnect_flag_reg <= disconnect_in;
		end
	end

	// ------------------------------------------------------------
	// Strap sensing and capture
	// ------------------------------------------------------------
	logic [STRAP_W-1:0] pin_meta_reg;
	logic [STRAP_W-1:0] pin_sync_reg;
	pxled_state_t       state_reg;
	pxled_state_t       state_next;
	logic [SETTLE_W-1:0] settle_reg;

	// Pin levels are asynchronous; two flops before anything looks at them
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
		end else begin
			pin_meta_reg <= strap_pin_in;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// Capture after the sync chain has flushed the zeros that reset loaded into it
	wire settle_done = (settle_reg == SETTLE_W'(STRAP_SETTLE_CYCLES - 1));

	always_comb begin
		case (state_reg)
			PXLED_ST_SENSE: state_next = settle_done ? PXLED_ST_RUN : PXLED_ST_SENSE;
			PXLED_ST_RUN:   state_next = PXLED_ST_RUN;
			default:        state_next = PXLED_ST_SENSE;
		endcase
	end

	// Reset restarts the sensing phase; pins stay released until capture
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			state_reg      <= PXLED_ST_SENSE;
			settle_reg     <= '0;
			strap_addr_reg <= STRAP_ISOLATE;
		end else begin
			state_reg <= state_next;
			if (state_reg == PXLED_ST_SENSE) begin
				settle_reg <= settle_reg + 1'b1;
			end
			if (state_reg == PXLED_ST_SENSE && settle_done) begin
				strap_addr_reg <= pin_sync_reg;
			end
		end
	end

	// Address zero isolates; before capture the address also reads zero
	wire addr_zero = (strap_addr_reg == STRAP_ISOLATE);
	wire pins_run  = (state_reg == PXLED_ST_RUN);

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			isolate_out       <= 1'b1;
			strap_address_out <= STRAP_ISOLATE;
		end else begin
			isolate_out       <= isolate_reg | addr_zero;
			strap_address_out <= strap_addr_reg;
		end
	end

	// ------------------------------------------------------------
	// Dual-role pins
	// ------------------------------------------------------------

	// Bit three is input only; the board straps it we never drive it
	assign loopback_enable_oe_out = pins_run;
	assign encode_select_oe_out   = pins_run;
	assign carrier_sense_oe_out   = pins_run;
	assign rx_error_oe_out        = pins_run;

	// Normal output values registered so the pins never glitch
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			loopback_enable_out <= 1'b0;
			encode_select_out   <= 1'b0;
			carrier_sense_out   <= 1'b0;
			rx_error_out        <= 1'b0;
		end else begin
			loopback_enable_out <= loopback_enable_in;
			encode_select_out   <= encode_select_in;
			carrier_sense_out   <= carrier_sense_in;
			rx_error_out        <= rx_error_in;
		end
	end

	// ------------------------------------------------------------
	// Activity stretch
	// ------------------------------------------------------------
	logic tx_stretched;
	logic rx_stretched;

	pxled_stretch #(
		.HOLD_CYCLES (STRETCH_CYCLES_P)
	) u_tx_stretch (
		.clock_in   (clock_in),
		.rst_n_in   (rst_n_in),
		.act_in     (tx_active_in),
		.active_out (tx_stretched)
	);

	pxled_stretch #(
		.HOLD_CYCLES (STRETCH_CYCLES_P)
	) u_rx_stretch (
		.clock_in   (clock_in),
		.rst_n_in   (rst_n_in),
		.act_in     (carrier_sense_in),
		.active_out (rx_stretched)
	);

	// ------------------------------------------------------------
	// Indicator selection
	// ------------------------------------------------------------

	// Alternate transmit meaning bypasses the stretch: it is a steady state
	wire tx_src  = tx_alt_reg ? disconnect_flag_reg : tx_stretched;
	// Duplex shown at 100, or always when the alternate mode is chosen
	wire pol_src = (dup_alt_reg | speed_100_in) ? full_duplex_in : polarity_good_in;

	// Outputs are active low and off while reset holds
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			tx_activity_indicator_n_out     <= IND_OFF;
			rx_activity_indicator_n_out     <= IND_OFF;
			link_good_indicator_n_out       <= IND_OFF;
			polarity_duplex_indicator_n_out <= IND_OFF;
			collision_indicator_n_out       <= IND_OFF;
		end else begin
			tx_activity_indicator_n_out     <= ~tx_src;
			rx_activity_indicator_n_out     <= ~rx_stretched;
			link_good_indicator_n_out       <= ~link_good_in;
			polarity_duplex_indicator_n_out <= ~pol_src;
			// Follows collision even in full duplex, where it means nothing
			collision_indicator_n_out       <= ~collision_in;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_tx_activity_on: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		($past(tx_active_in, 2) && $past(rst_n_in, 2) && $past(rst_n_in) && !$past(tx_alt_reg))
		|-> !tx_activity_indicator_n_out)
		else $error("transmit indicator off after transmit activity");

	chk_tx_alt_mode: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		$past(tx_alt_reg) |-> (tx_activity_indicator_n_out == !$past(disconnect_flag_reg)))
		else $error("transmit indicator not following disconnect state");

	chk_rx_activity_on: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(rst_n_in && carrier_sense_in) ##1 !carrier_sense_in |=> !rx_activity_indicator_n_out [*2])
		else $error("receive indicator not held after carrier sense");

	chk_link_follow: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		($past(link_good_in) && $past(rst_n_in)) |-> !link_good_indicator_n_out)
		else $error("link indicator off while link is good");

	chk_pol_default: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		($past(rst_n_in) && !$past(dup_alt_reg) && !$past(speed_100_in))
		|-> (polarity_duplex_indicator_n_out == !$past(polarity_good_in)))
		else $error("polarity indicator wrong in 10 Mb/s default mode");

	chk_pol_duplex: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		($past(rst_n_in) && ($past(dup_alt_reg) || $past(speed_100_in)))
		|-> (polarity_duplex_indicator_n_out == !$past(full_duplex_in)))
		else $error("duplex indicator not showing full duplex state");

	chk_collision_on: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(rst_n_in && collision_in) |=> !collision_indicator_n_out)
		else $error("collision indicator off during collision");

	chk_strap_capture: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(state_reg == PXLED_ST_SENSE && settle_done)
		|=> (state_reg == PXLED_ST_RUN && strap_addr_reg == $past(pin_sync_reg)))
		else $error("strap address not captured at end of sensing");

	chk_isolate_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		addr_zero |=> isolate_out)
		else $error("zero strap address did not isolate");

	chk_pins_released: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(state_reg == PXLED_ST_SENSE) |-> !(loopback_enable_oe_out || encode_select_oe_out
		|| carrier_sense_oe_out || rx_error_oe_out))
		else $error("strap pin driven during sensing");

	chk_settle_time: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		$rose(rst_n_in) |-> (state_reg == PXLED_ST_SENSE) [*4] ##1 pins_run)
		else $error("sensing phase length wrong after reset");

	chk_reset_idle: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		$rose(rst_n_in) |-> (tx_activity_indicator_n_out && rx_activity_indicator_n_out
		&& link_good_indicator_n_out && polarity_duplex_indicator_n_out
		&& collision_indicator_n_out))
		else $error("indicator lit straight after reset");

	chk_bus_answer: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(bus_req && waitrequest_out) |=> !waitrequest_out)
		else $error("bus request not answered in one cycle");

endmodule

// File: logic/pxled_pkg.sv
// Package of constants and types for the indicator and address strap block
package pxled_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS       = 10;
	// Visible on-time that an activity indication is held for
	localparam int STRETCH_TIME_NS     = 50_000_000;
	// Least time rounds up to whole cycles
	localparam int STRETCH_CYCLES      = (STRETCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Pins are sensed for this many cycles after reset before the capture
	localparam int STRAP_SETTLE_CYCLES = 4;

	// ------------------------------------------------------------
	// Bus geometry and register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam int         ADDR_W         = 8;
	localparam int         DATA_W         = 32;
	localparam logic [5:0] IDX_BASIC_CTRL = 6'h00;
	localparam logic [5:0] IDX_PCS_CFG    = 6'h17;
	localparam logic [5:0] IDX_STRAP_ADDR = 6'h19;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BCR_ISOLATE_BIT     = 10;
	localparam int CFG_DUPLEX_ALT_BIT  = 1;
	localparam int CFG_TX_ALT_BIT      = 2;
	localparam int ADR_DISCONNECT_BIT  = 5;
	localparam int STRAP_W             = 5;
	localparam int STRAP_INPUT_BIT     = 3;

	// ------------------------------------------------------------
	// Values after reset
	// ------------------------------------------------------------
	localparam logic               ISOLATE_RESET    = 1'b0;
	localparam logic               TX_ALT_RESET     = 1'b0;
	localparam logic               DUPLEX_ALT_RESET = 1'b0;
	localparam logic               IND_OFF          = 1'b1;
	localparam logic [STRAP_W-1:0] STRAP_ISOLATE    = 5'h00;

	// Strap sensing phase, then normal pin roles
	typedef enum logic [0:0] {
		PXLED_ST_SENSE = 1'b0,
		PXLED_ST_RUN   = 1'b1
	} pxled_state_t;

endpackage

// File: logic/pxled_stretch.sv
// Monostable stretch of an activity level for a visible indicator
`timescale 1ns/1ns
module pxled_stretch #(
	parameter int HOLD_CYCLES = pxled_pkg::STRETCH_CYCLES
) (
	// Clock and reset
	input  wire logic clock_in,
	input  wire logic rst_n_in,
	// Activity level and stretched result
	input  wire logic act_in,
	output logic      active_out
);
	import pxled_pkg::*;

	localparam int CNT_W = $clog2(HOLD_CYCLES + 1);

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	generate
		if (HOLD_CYCLES < 1) begin : g_bad_hold
			$error("pxled_stretch: HOLD_CYCLES must be at least 1");
		end
	endgenerate

	// ------------------------------------------------------------
	// Hold counter
	// ------------------------------------------------------------
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	wire              cnt_busy = (cnt_reg != '0);

	// Reload on every active cycle so a burst of short packets keeps it lit
	assign cnt_next = act_in ? CNT_W'(HOLD_CYCLES) :
		(cnt_busy ? cnt_reg - 1'b1 : cnt_reg);

	// Counter cleared and indication off while reset holds
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			cnt_reg    <= '0;
			active_out <= 1'b0;
		end else begin
			cnt_reg    <= cnt_next;
			active_out <= act_in | cnt_busy;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_stretch_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(rst_n_in && act_in) ##1 !act_in |=> active_out [*2])
		else $error("stretch released too soon after activity");

	chk_stretch_ends: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(!act_in && !cnt_busy) |=> !active_out)
		else $error("stretch held with no activity and an empty counter");

endmodule

// File: bench/pxled_partner.sv
// Board strap network seen by the dual-role address pins
`timescale 1ns/1ns
module pxled_partner (
	// Resistor pattern fitted on the board
	input  wire logic [4:0] pull_in,
	// Driven side of the dual-role pins
	input  wire logic [4:0] drive_in,
	input  wire logic [4:0] oe_in,
	// Resolved pin levels
	output logic      [4:0] pin_out
);
	// A released pin falls back to its resistor; bit 3 is only ever a strap
	assign pin_out = (oe_in & drive_in) | (~oe_in & pull_in);
endmodule

// File: bench/tb_pxled_top.sv
// Self-checking bench for the indicator and address strap block
`timescale 1ns/1ns
module tb_pxled_top;
	import pxled_pkg::*;
	`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
		$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
	// Short stretch keeps the run brief
	localparam int STR = 8;
	int          failures = 0;
	int          n_compared = 0;
	logic        clock_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [7:0]  address_in = 8'h00;
	logic        read_in = 1'b0, write_in = 1'b0;
	logic [31:0] writedata_in = 32'h0, rd, readdata_out;
	logic        waitrequest_out;
	logic        tx = 0, crs = 0, lk = 1, pol = 0, fd = 0, spd = 0, col = 0, dis = 0;
	logic        lb = 0, enc = 0, rxe = 0;
	logic [4:0]  pull = 5'h0a, pins, adr, tb_tbl [6];
	wire  [4:0]  drv, oe;
	logic        tx_n, rx_n, lk_n, pd_n, col_n, iso;

	assign drv[3] = 1'b0;
	assign oe[3] = 1'b0;
	always #5 clock_in = ~clock_in;

	pxled_top #(.STRETCH_CYCLES_P(STR)) pxled_top_inst (
		.clock_in(clock_in), .rst_n_in(rst_n_in), .address_in(address_in),
		.read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
		.byteenable_in(4'hf), .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
		.tx_active_in(tx), .carrier_sense_in(crs), .link_good_in(lk),
		.polarity_good_in(pol), .full_duplex_in(fd), .speed_100_in(spd),
		.collision_in(col), .disconnect_in(dis), .loopback_enable_in(lb),
		.encode_select_in(enc), .rx_error_in(rxe),
		.tx_activity_indicator_n_out(tx_n), .rx_activity_indicator_n_out(rx_n),
		.link_good_indicator_n_out(lk_n), .polarity_duplex_indicator_n_out(pd_n),
		.collision_indicator_n_out(col_n), .strap_pin_in(pins),
		.loopback_enable_out(drv[0]), .loopback_enable_oe_out(oe[0]),
		.encode_select_out(drv[1]), .encode_select_oe_out(oe[1]),
		.carrier_sense_out(drv[2]), .carrier_sense_oe_out(oe[2]),
		.rx_error_out(drv[4]), .rx_error_oe_out(oe[4]),
		.strap_address_out(adr), .isolate_out(iso));

	pxled_partner pxled_partner_inst (.pull_in(pull), .drive_in(drv), .oe_in(oe),
		.pin_out(pins));

	// -------------------------------------------------------------
	// Bus access and timing helpers
	// -------------------------------------------------------------
	// Request held until waitrequest is seen low at a rising edge; only the watchdog ends a hang
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		read_in <= !wr;
		write_in <= wr;
		address_in <= a;
		writedata_in <= d;
		#1;
		while (waitrequest_out !== 1'b0) begin
			@(posedge clock_in);
			#1;
		end
		@(posedge clock_in);
		rd = readdata_out;
		read_in <= 1'b0;
		write_in <= 1'b0;
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask

	task automatic tally_and_finish;
		$display("compared=%0d failures=%0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// -------------------------------------------------------------
	// Test sequence
	// -------------------------------------------------------------
	initial begin
		// Entries: alt select, speed 100, polarity, duplex, expected pin
		tb_tbl = '{5'h04, 5'h03, 5'h0a, 5'h0d, 5'h15, 5'h12};
		wt(4);
		`CHK({tx_n, rx_n, lk_n, pd_n, col_n, iso, oe}, 11'h7e0)
		@(posedge clock_in);
		rst_n_in <= 1'b1;
		wt(2);
		`CHK(oe, 5'h00)
		wt(6);
		`CHK({adr, iso, oe}, {5'h0a, 1'b0, 5'h17})
		@(posedge clock_in);
		lb <= 1'b1;
		rxe <= 1'b1;
		enc <= 1'b1;
		wt(3);
		`CHK(pins, 5'h1b)
		bus(1'b0, {IDX_STRAP_ADDR, 2'b00}, 32'h0);
		`CHK(rd, 32'h0000000a)
		bus(1'b1, {IDX_STRAP_ADDR, 2'b00}, 32'h1f);
		bus(1'b0, {IDX_STRAP_ADDR, 2'b00}, 32'h0);
		`CHK(rd, 32'h0000000a)
		bus(1'b0, 8'h40, 32'h0);
		`CHK(rd, 32'h00000000)
		// One-cycle activity must stay visible for the whole stretch
		@(posedge clock_in);
		tx <= 1'b1;
		crs <= 1'b1;
		@(posedge clock_in);
		tx <= 1'b0;
		crs <= 1'b0;
		for (int i = 2; i <= STR + 2; i++) begin
			wt(1);
			`CHK({tx_n, rx_n}, 2'b00)
		end
		wt(1);
		`CHK({tx_n, rx_n}, 2'b11)
		`CHK(lk_n, 1'b0)
		@(posedge clock_in);
		col <= 1'b1;
		fd <= 1'b1;
		wt(3);
		`CHK(col_n, 1'b0)
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, {IDX_PCS_CFG, 2'b00}, {30'h0, tb_tbl[i][4], 1'b0});
			{spd, pol, fd} <= tb_tbl[i][3:1];
			wt(4);
			`CHK(pd_n, tb_tbl[i][0])
		end
		bus(1'b1, {IDX_PCS_CFG, 2'b00}, 32'h4);
		dis <= 1'b1;
		wt(4);
		`CHK(tx_n, 1'b0)
		bus(1'b0, {IDX_STRAP_ADDR, 2'b00}, 32'h0);
		`CHK(rd[5], 1'b1)
		dis <= 1'b0;
		wt(4);
		`CHK(tx_n, 1'b1)
		bus(1'b1, {IDX_BASIC_CTRL, 2'b00}, 32'h400);
		wt(3);
		`CHK(iso, 1'b1)
		bus(1'b1, {IDX_BASIC_CTRL, 2'b00}, 32'h0);
		wt(3);
		`CHK(iso, 1'b0)
		// All-zero straps on purpose, with activity running through reset
		@(posedge clock_in);
		pull <= 5'h00;
		tx <= 1'b1;
		rst_n_in <= 1'b0;
		wt(3);
		`CHK({tx_n, lk_n, iso}, 3'b111)
		@(posedge clock_in);
		rst_n_in <= 1'b1;
		tx <= 1'b0;
		wt(8);
		`CHK({adr, iso}, {5'h00, 1'b1})
		tally_and_finish();
	end

	// Whole run is under two hundred cycles; this cuts a hang short
	initial begin
		#100000;
		failures++;
		tally_and_finish();
	end
endmodule
